/* hw/line_ctrl_pkg.sv */
// Package: offsets, field positions and types for the line interface control bank
package line_ctrl_pkg;
  // ==========================================================
  // Register offsets on the parallel control port
  localparam logic [7:0] OFS_CTRL_B = 8'h31;
  localparam logic [7:0] OFS_CTRL_C = 8'h32;
  localparam logic [7:0] OFS_CTRL_D = 8'h33;
  localparam logic [7:0] OFS_BUILDOUT = 8'h34;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // ==========================================================
  // Field positions, line_interface_ctrl_b
  localparam int B_CUSTOM_DRIVER = 0;
  localparam int B_LIMIT_DISABLE = 1;
  localparam int B_CC_FILTER = 2;
  localparam int B_ATTEN_LO = 3;
  localparam int B_TX_ALARM = 4;
  localparam int B_VIOLATION = 5;
  localparam int B_LINE_RESET = 6;
  localparam int B_ATTEN_HI = 7;
  // Field positions, line_interface_ctrl_c
  localparam int C_ALT_PATTERN = 0;
  localparam int C_MON_LO = 3;
  localparam int C_EXT_133 = 5;
  localparam int C_CMI_INVERT = 6;
  localparam int C_CMI_ENABLE = 7;
  // Field positions, line_interface_ctrl_d
  localparam int D_RX_TERM_LO = 0;
  localparam int D_TX_TERM_LO = 3;
  localparam int D_PRESCALE_LO = 6;
  localparam int D_PRESCALE_HI = 7;
  // Field positions, transmit_buildout_gain
  localparam int G_MANUAL = 6;
  localparam int G_LEVEL_W = 6;
  // Consecutive ones that open a violation slot
  localparam logic [1:0] ONES_FOR_VIOLATION = 2'h3;
  // ==========================================================
  typedef enum logic [1:0] {
    MODE_T1 = 2'b00,
    MODE_E1 = 2'b01,
    MODE_J1 = 2'b10,
    MODE_CC = 2'b11
  } line_mode_e;
  typedef enum logic [1:0] {
    PAT_NORMAL = 2'b00,
    PAT_ALL_ONES = 2'b01,
    PAT_ALTERNATE = 2'b10
  } tx_pattern_e;
  // Termination choice; TERM_EXT means the external resistor alone
  typedef enum logic [2:0] {
    TERM_EXT = 3'b000,
    TERM_75 = 3'b001,
    TERM_100 = 3'b010,
    TERM_120 = 3'b011,
    TERM_110 = 3'b100,
    TERM_133 = 3'b101,
    TERM_OFF = 3'b110
  } term_e;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_s;
  typedef struct packed {
    logic [1:0] prescale;
    logic atten_select_lo;
    logic pll_enable;
  } atten_clock_s;
endpackage

/* hw/line_interface_control_bank.sv */
// Line interface control bank: registers, field decode and transmit shaping
//
// Contract
// R01: Gain mode bit picks auto or manual level
// R02: Custom driver: square wave or open-drain outputs
// R03: E1 current limiter enabled unless disable set
// R04: Composite filter only on 64k clock
// R05: Select and prescaler bits choose attenuator clock
// R06: Upper select bit enables conversion PLL
// R07: Line modes: alarm zero sends all ones
// R08: Composite modes: alarm zero drops violations
// R09: Rising violation bit arms one violation
// R10: Rising reset bit pulses line reset
// R11: Alternating bit sends one-zero pattern
// R12: Software writes zero to unused bits
// R13: Monitor gain boost only T1 or E1
// R14: Software flags fitted external resistor value
// R15: Receive termination decode with 133 rule
// R16: Transmit termination decode table
// R17: Mark inversion coding enable both directions
// R18: Mark inversion polarity inverts both tips
// R19: Reset zero; hardware mode follows pins
// R20: Ones hold alternate level, zeros rise mid
// R21: E1 master clock maps to prescaler settings
// R22: Write compare makes one-cycle trigger pulses
`timescale 1ns/1ps
module line_interface_control_bank
  import line_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Parallel control port
  input wire host_req_s host_req,
  output logic [7:0] rdata_ff,
  // Hardware mode straps
  input wire logic hw_mode,
  input wire logic pin_tx_alarm,
  input wire logic pin_atten_lo,
  input wire logic pin_prescale_lo,
  input wire logic pin_prescale_hi,
  // Line configuration from the rest of the device
  input wire line_mode_e line_mode,
  input wire logic [2:0] buildout_sel,
  // Transmit bit stream
  input wire logic tx_bit_valid,
  input wire logic tx_mid,
  input wire logic tx_bit,
  output logic tx_line_pos_ff,
  output logic violation_pulse_ff,
  // Receive tip
  input wire logic rx_line_pos,
  output logic rx_cmi_level_ff,
  // Decoded controls
  output logic manual_gain_ff,
  output logic [5:0] gain_level_ff,
  output logic square_wave_ff,
  output logic open_drain_ff,
  output logic current_limit_ff,
  output logic cc_filter_ff,
  output logic subrate_violations_ff,
  output atten_clock_s attenuator_clock_ff,
  output logic line_reset_pulse_ff,
  output logic [1:0] monitor_boost_ff,
  output term_e rx_term_ff,
  output term_e tx_term_ff,
  output logic cmi_enable_ff
);
  // ==========================================================
  // Register storage
  logic [7:0] ctrl_b_ff;
  logic [7:0] ctrl_c_ff;
  logic [7:0] ctrl_d_ff;
  logic [7:0] buildout_ff;
  logic [7:0] eff_b;
  logic [7:0] eff_c;
  logic [7:0] eff_d;
  logic [7:0] eff_g;
  logic violation_armed_ff;
  logic violation_rise;
  logic reset_rise;
  logic [1:0] ones_run_ff;
  logic alt_bit_ff;
  logic cur_bit_ff;
  logic last_one_ff;
  logic sel_bit;
  tx_pattern_e pattern;
  logic line_family;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_b_ff <= RESET_VALUE; // R19
      ctrl_c_ff <= RESET_VALUE;
      ctrl_d_ff <= RESET_VALUE;
      buildout_ff <= RESET_VALUE;
    end else if (host_req.wr) begin
      // Unused bits are stored as written; software keeps them zero
      unique case (host_req.addr)
        OFS_CTRL_B: ctrl_b_ff <= host_req.wdata;
        OFS_CTRL_C: ctrl_c_ff <= host_req.wdata;
        OFS_CTRL_D: ctrl_d_ff <= host_req.wdata;
        OFS_BUILDOUT: buildout_ff <= host_req.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Hardware mode: pinned fields follow pins, all others read zero
  always_comb begin
    eff_b = ctrl_b_ff;
    eff_c = ctrl_c_ff;
    eff_d = ctrl_d_ff;
    eff_g = buildout_ff;
    if (hw_mode) begin
      eff_b = 8'h00; // R19
      eff_b[B_TX_ALARM] = pin_tx_alarm;
      eff_b[B_ATTEN_LO] = pin_atten_lo;
      eff_c = 8'h00;
      eff_d = 8'h00;
      eff_d[D_PRESCALE_LO] = pin_prescale_lo;
      eff_d[D_PRESCALE_HI] = pin_prescale_hi;
      eff_g = 8'h00;
    end
  end

  // Rising edges seen by comparing the write with the stored value
  assign violation_rise = host_req.wr && !hw_mode && host_req.addr == OFS_CTRL_B &&
    !ctrl_b_ff[B_VIOLATION] && host_req.wdata[B_VIOLATION]; // R22
  assign reset_rise = host_req.wr && !hw_mode && host_req.addr == OFS_CTRL_B &&
    !ctrl_b_ff[B_LINE_RESET] && host_req.wdata[B_LINE_RESET]; // R22

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (host_req.rd) begin
      unique case (host_req.addr)
        OFS_CTRL_B: rdata_ff <= eff_b;
        OFS_CTRL_C: rdata_ff <= eff_c;
        OFS_CTRL_D: rdata_ff <= eff_d;
        OFS_BUILDOUT: rdata_ff <= eff_g;
        default: rdata_ff <= UNMAPPED_READ;
      endcase
    end
  end

  // ==========================================================
  // Static decode of the control fields
  assign line_family = line_mode != MODE_CC;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      manual_gain_ff <= 1'b0;
      gain_level_ff <= 6'h00;
      square_wave_ff <= 1'b0;
      open_drain_ff <= 1'b0;
      current_limit_ff <= 1'b0;
      cc_filter_ff <= 1'b0;
      subrate_violations_ff <= 1'b0;
      attenuator_clock_ff <= '0;
      monitor_boost_ff <= 2'h0;
      cmi_enable_ff <= 1'b0;
    end else begin
      manual_gain_ff <= eff_g[G_MANUAL]; // R01
      // Automatic gain: the manual level is ignored
      gain_level_ff <= eff_g[G_MANUAL] ? eff_g[G_LEVEL_W-1:0] : 6'h00; // R01
      square_wave_ff <= eff_b[B_CUSTOM_DRIVER] && buildout_sel == 3'h0; // R02
      open_drain_ff <= eff_b[B_CUSTOM_DRIVER] && buildout_sel != 3'h0; // R02
      current_limit_ff <= line_mode == MODE_E1 && !eff_b[B_LIMIT_DISABLE]; // R03
      // Only the 64k clock is filtered; 8k and 400Hz stay raw
      cc_filter_ff <= line_mode == MODE_CC && eff_b[B_CC_FILTER]; // R04
      subrate_violations_ff <= line_mode == MODE_CC && eff_b[B_TX_ALARM]; // R08
      // Mapping of master clock to settings is software's table
      attenuator_clock_ff.prescale <= {eff_d[D_PRESCALE_HI], eff_d[D_PRESCALE_LO]}; // R05 R21
      attenuator_clock_ff.atten_select_lo <= eff_b[B_ATTEN_LO]; // R05
      attenuator_clock_ff.pll_enable <= eff_b[B_ATTEN_HI]; // R06
      monitor_boost_ff <= (line_mode == MODE_T1 || line_mode == MODE_E1) ?
        eff_c[C_MON_LO+1:C_MON_LO] : 2'h0; // R13
      cmi_enable_ff <= eff_c[C_CMI_ENABLE]; // R17
    end
  end

  // ==========================================================
  // Termination decode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_term_ff <= TERM_EXT;
      tx_term_ff <= TERM_OFF;
    end else begin
      unique case (eff_d[D_RX_TERM_LO+2:D_RX_TERM_LO]) // R15
        3'h1: rx_term_ff <= TERM_75;
        3'h2: rx_term_ff <= TERM_100;
        3'h3: rx_term_ff <= TERM_120;
        3'h4: rx_term_ff <= TERM_110;
        // 133 ohm needs the 133 ohm resistor fitted
        3'h5: rx_term_ff <= eff_c[C_EXT_133] ? TERM_133 : TERM_EXT; // R14
        default: rx_term_ff <= TERM_EXT;
      endcase
      unique case (eff_d[D_TX_TERM_LO+2:D_TX_TERM_LO]) // R16
        3'h1: tx_term_ff <= TERM_75;
        3'h2: tx_term_ff <= TERM_100;
        3'h3: tx_term_ff <= TERM_120;
        3'h4: tx_term_ff <= TERM_110;
        3'h5: tx_term_ff <= TERM_133;
        default: tx_term_ff <= TERM_OFF;
      endcase
    end
  end

  // ==========================================================
  // Line reset and violation arming
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      line_reset_pulse_ff <= 1'b0;
    end else begin
      line_reset_pulse_ff <= reset_rise; // R10
    end
  end

  // Alarm wins over the alternating pattern
  always_comb begin
    pattern = PAT_NORMAL;
    if (!eff_b[B_TX_ALARM]) begin
      pattern = PAT_ALL_ONES; // R07 R08
    end else if (eff_c[C_ALT_PATTERN]) begin
      pattern = PAT_ALTERNATE; // R11
    end
    unique case (pattern)
      PAT_ALL_ONES: sel_bit = 1'b1;
      PAT_ALTERNATE: sel_bit = alt_bit_ff;
      default: sel_bit = tx_bit;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alt_bit_ff <= 1'b0;
      ones_run_ff <= 2'h0;
      violation_armed_ff <= 1'b0;
      violation_pulse_ff <= 1'b0;
    end else begin
      violation_pulse_ff <= 1'b0;
      if (tx_bit_valid) begin
        alt_bit_ff <= !alt_bit_ff; // R11
        if (!sel_bit) begin
          ones_run_ff <= 2'h0;
        end else if (ones_run_ff != ONES_FOR_VIOLATION) begin
          ones_run_ff <= ones_run_ff + 2'h1;
        end
      end
      // Third or later one of a run; a saturated run during all ones still qualifies
      if (violation_armed_ff && tx_bit_valid && sel_bit &&
          ones_run_ff >= ONES_FOR_VIOLATION - 2'h1) begin
        violation_armed_ff <= violation_rise;
        violation_pulse_ff <= 1'b1; // R09
      end else if (violation_rise) begin
        violation_armed_ff <= 1'b1; // R09
      end
    end
  end

  // ==========================================================
  // Line coding: plain NRZ or mark inversion
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cur_bit_ff <= 1'b0;
      last_one_ff <= 1'b0;
      tx_line_pos_ff <= 1'b0;
      rx_cmi_level_ff <= 1'b0;
    end else begin
      rx_cmi_level_ff <= rx_line_pos ^ (eff_c[C_CMI_ENABLE] && eff_c[C_CMI_INVERT]); // R18
      if (tx_bit_valid) begin
        cur_bit_ff <= sel_bit;
        if (!eff_c[C_CMI_ENABLE]) begin
          tx_line_pos_ff <= sel_bit; // R17
        end else if (sel_bit) begin
          // Ones hold a whole-period level that alternates
          last_one_ff <= !last_one_ff;
          tx_line_pos_ff <= !last_one_ff ^ eff_c[C_CMI_INVERT]; // R20 R18
        end else begin
          tx_line_pos_ff <= eff_c[C_CMI_INVERT]; // R20
        end
      end else if (tx_mid && eff_c[C_CMI_ENABLE] && !cur_bit_ff) begin
        tx_line_pos_ff <= !eff_c[C_CMI_INVERT]; // R20
      end
    end
  end

  // ==========================================================
  // Checks
  gain_auto_a: assert property (@(posedge clock) disable iff (rst) // R01
    !eff_g[G_MANUAL] |=> gain_level_ff == 6'h00)
    else $error("auto gain leaked level");
  driver_mode_a: assert property (@(posedge clock) disable iff (rst) // R02
    !(square_wave_ff && open_drain_ff))
    else $error("square and open-drain both on");
  limiter_e1_a: assert property (@(posedge clock) disable iff (rst) // R03
    line_mode != MODE_E1 |=> !current_limit_ff)
    else $error("limiter outside E1");
  filter_cc_a: assert property (@(posedge clock) disable iff (rst) // R04
    line_mode != MODE_CC |=> !cc_filter_ff)
    else $error("filter outside composite mode");
  pll_select_a: assert property (@(posedge clock) disable iff (rst) // R06
    1'b1 |=> attenuator_clock_ff.pll_enable == $past(eff_b[B_ATTEN_HI]))
    else $error("pll enable mismatch");
  reset_pulse_a: assert property (@(posedge clock) disable iff (rst) // R10
    line_reset_pulse_ff |=> !line_reset_pulse_ff)
    else $error("line reset pulse too long");
  alarm_ones_a: assert property (@(posedge clock) disable iff (rst) // R07
    tx_bit_valid && !eff_b[B_TX_ALARM] && !eff_c[C_CMI_ENABLE] |=> tx_line_pos_ff)
    else $error("alarm not all ones");
  boost_mode_a: assert property (@(posedge clock) disable iff (rst) // R13
    line_mode inside {MODE_J1, MODE_CC} |=> monitor_boost_ff == 2'h0)
    else $error("boost outside T1 or E1");
  rx_term_a: assert property (@(posedge clock) disable iff (rst) // R15
    eff_d[2:0] == 3'h5 && !eff_c[C_EXT_133] |=> rx_term_ff == TERM_EXT)
    else $error("133 ohm without resistor");
  violation_one_a: assert property (@(posedge clock) disable iff (rst) // R09
    violation_pulse_ff |-> $past(violation_armed_ff) && $past(sel_bit))
    else $error("violation without arming");
  hw_zero_a: assert property (@(posedge clock) disable iff (rst) // R19
    hw_mode |=> !cmi_enable_ff && tx_term_ff == TERM_OFF)
    else $error("hardware mode field not zero");
  subrate_cc_a: assert property (@(posedge clock) disable iff (rst) // R08
    line_mode != MODE_CC |=> !subrate_violations_ff)
    else $error("sub-rate control outside composite mode");
  reset_quiet_a: assert property (@(posedge clock) disable iff (rst) // R22
    !reset_rise |=> !line_reset_pulse_ff)
    else $error("line reset pulse without rising bit");
  tx_term_off_a: assert property (@(posedge clock) disable iff (rst) // R16
    eff_d[D_TX_TERM_LO+2:D_TX_TERM_LO] inside {3'h0, 3'h6, 3'h7} |=> tx_term_ff == TERM_OFF)
    else $error("transmit termination not disabled");
  cmi_zero_a: assert property (@(posedge clock) disable iff (rst) // R20
    tx_bit_valid && eff_c[C_CMI_ENABLE] && !sel_bit |=>
      tx_line_pos_ff == $past(eff_c[C_CMI_INVERT]))
    else $error("mark inversion zero first half wrong");
  cmi_mid_a: assert property (@(posedge clock) disable iff (rst) // R20
    tx_mid && !tx_bit_valid && eff_c[C_CMI_ENABLE] && !cur_bit_ff |=>
      tx_line_pos_ff != $past(eff_c[C_CMI_INVERT]))
    else $error("mark inversion zero missed mid transition");
  rx_plain_a: assert property (@(posedge clock) disable iff (rst) // R18
    !eff_c[C_CMI_ENABLE] |=> rx_cmi_level_ff == $past(rx_line_pos))
    else $error("receive tip inverted outside mark inversion");
  gain_manual_a: assert property (@(posedge clock) disable iff (rst) // R01
    eff_g[G_MANUAL] |=> gain_level_ff == $past(eff_g[G_LEVEL_W-1:0]))
    else $error("manual gain level not applied");
  hw_pins_a: assert property (@(posedge clock) disable iff (rst) // R19
    hw_mode |=> attenuator_clock_ff.prescale == $past({pin_prescale_hi, pin_prescale_lo}))
    else $error("prescaler not following pins");
endmodule

/* tb/line_far_end.sv */
// Far end of the line: drives the receive tip of the control bank
`timescale 1ns/1ps
module line_far_end (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Receive line
  input wire logic send_level,
  output logic rx_line_pos
);
  // ==========================================================
  // Registered so the tip never changes in the bank's sampling step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_line_pos <= 1'h0;
    end else begin
      rx_line_pos <= send_level;
    end
  end
endmodule

/* tb/tb.sv */
// Self-checking testbench for the line interface control bank
`timescale 1ns/1ps
module tb;
  import line_ctrl_pkg::*;
  // ==========================================================
  // Stimulus and observed outputs
  logic clock = 1'h0;
  logic rst = 1'h1;
  host_req_s host_req = '0;
  logic hw_mode = 1'h0;
  logic [3:0] pins = 4'h0;
  line_mode_e line_mode = MODE_T1;
  logic [2:0] buildout_sel = 3'h0;
  logic tx_bit_valid = 1'h0;
  logic tx_mid = 1'h0;
  logic tx_bit = 1'h0;
  logic send_level = 1'h0;
  logic rx_line_pos, tx_line_pos_ff, violation_pulse_ff, rx_cmi_level_ff, manual_gain_ff;
  logic square_wave_ff, open_drain_ff, current_limit_ff, cc_filter_ff, subrate_violations_ff;
  logic line_reset_pulse_ff, cmi_enable_ff;
  logic [7:0] rdata_ff;
  logic [5:0] gain_level_ff;
  logic [1:0] monitor_boost_ff;
  atten_clock_s attenuator_clock_ff;
  term_e rx_term_ff, tx_term_ff;
  int n_fail = 0;
  int check_count = 0;

  always #50 clock = ~clock;

  line_interface_control_bank u_dut (.clock, .rst, .host_req, .rdata_ff, .hw_mode,
    .pin_tx_alarm(pins[0]), .pin_atten_lo(pins[1]), .pin_prescale_lo(pins[2]),
    .pin_prescale_hi(pins[3]), .line_mode, .buildout_sel, .tx_bit_valid, .tx_mid, .tx_bit,
    .tx_line_pos_ff, .violation_pulse_ff, .rx_line_pos, .rx_cmi_level_ff, .manual_gain_ff,
    .gain_level_ff, .square_wave_ff, .open_drain_ff, .current_limit_ff, .cc_filter_ff,
    .subrate_violations_ff, .attenuator_clock_ff, .line_reset_pulse_ff, .monitor_boost_ff,
    .rx_term_ff, .tx_term_ff, .cmi_enable_ff);

  line_far_end u_far (.clock, .rst, .send_level, .rx_line_pos);

  // ==========================================================
  // Shared tasks
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    host_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
    @(posedge clock);
    host_req.wr <= 1'h0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    host_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
    @(posedge clock);
    host_req.rd <= 1'h0;
    #1;
    cmp(rdata_ff, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask
  // Pulse may land on either edge after the write, so count over three
  task automatic reset_pulses(output logic [7:0] n);
    n = 8'h00;
    repeat (3) begin
      #1;
      n = n + {7'h00, line_reset_pulse_ff};
      @(posedge clock);
    end
  endtask
  task automatic send(input logic b, output logic pos, output logic viol);
    @(posedge clock);
    tx_bit_valid <= 1'h1;
    tx_bit <= b;
    @(posedge clock);
    tx_bit_valid <= 1'h0;
    #1;
    pos = tx_line_pos_ff;
    viol = violation_pulse_ff;
    @(posedge clock);
    #1;
    viol = viol | violation_pulse_ff;
  endtask
  task automatic mid(output logic pos);
    @(posedge clock);
    tx_mid <= 1'h1;
    @(posedge clock);
    tx_mid <= 1'h0;
    #1;
    pos = tx_line_pos_ff;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] val [4];
    val = '{8'ha5, 8'hf9, 8'hc3, 8'h7f};
    settle();
    cmp(8'(tx_term_ff), 8'(TERM_OFF));
    cmp(8'(attenuator_clock_ff), 8'h00);
    for (int i = 0; i < 4; i++) rd_chk(OFS_CTRL_B + 8'(i), RESET_VALUE);
    for (int i = 0; i < 4; i++) wr(OFS_CTRL_B + 8'(i), val[i]);
    wr(8'h35, 8'hff);
    for (int i = 0; i < 4; i++) rd_chk(OFS_CTRL_B + 8'(i), val[i]);
    rd_chk(8'h35, UNMAPPED_READ);
    $display("test registers done");
  endtask
  task automatic t_gain_driver();
    wr(OFS_BUILDOUT, 8'h55);
    settle();
    cmp({manual_gain_ff, 1'h0, gain_level_ff}, 8'h95);
    wr(OFS_BUILDOUT, 8'h2a);
    settle();
    cmp({manual_gain_ff, 1'h0, gain_level_ff}, 8'h00);
    wr(OFS_CTRL_B, 8'h01);
    buildout_sel <= 3'h0;
    settle();
    cmp({6'h00, square_wave_ff, open_drain_ff}, 8'h02);
    buildout_sel <= 3'h3;
    settle();
    cmp({6'h00, square_wave_ff, open_drain_ff}, 8'h01);
    $display("test gain and driver done");
  endtask
  task automatic t_limit_filter();
    line_mode <= MODE_E1;
    wr(OFS_CTRL_B, 8'h10);
    settle();
    cmp_bit(current_limit_ff, 1'h1);
    wr(OFS_CTRL_B, 8'h12);
    settle();
    cmp_bit(current_limit_ff, 1'h0);
    line_mode <= MODE_CC;
    wr(OFS_CTRL_B, 8'h14);
    settle();
    cmp({6'h00, cc_filter_ff, subrate_violations_ff}, 8'h03);
    wr(OFS_CTRL_B, 8'h04);
    settle();
    cmp({6'h00, cc_filter_ff, subrate_violations_ff}, 8'h02);
    line_mode <= MODE_T1;
    settle();
    cmp_bit(cc_filter_ff, 1'h0);
    $display("test limiter and filter done");
  endtask
  task automatic t_atten();
    wr(OFS_CTRL_B, 8'h88);
    wr(OFS_CTRL_D, 8'h40);
    settle();
    cmp(8'(attenuator_clock_ff), 8'h07);
    wr(OFS_CTRL_B, 8'h80);
    wr(OFS_CTRL_D, 8'h00);
    settle();
    cmp(8'(attenuator_clock_ff), 8'h01);
    wr(OFS_CTRL_B, 8'h08);
    wr(OFS_CTRL_D, 8'hc0);
    settle();
    cmp(8'(attenuator_clock_ff), 8'h0e);
    $display("test attenuator clock done");
  endtask
  task automatic t_trigger();
    logic [7:0] n;
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_B, 8'h40);
    reset_pulses(n);
    cmp(n, 8'h01);
    wr(OFS_CTRL_B, 8'h40);
    reset_pulses(n);
    cmp(n, 8'h00);
    $display("test line reset done");
  endtask
  task automatic t_term();
    logic [2:0] c;
    logic [7:0] er;
    for (int i = 0; i < 16; i++) begin
      c = 3'(i);
      wr(OFS_CTRL_C, {2'h0, i[3], 5'h00});
      wr(OFS_CTRL_D, {2'h0, c, c});
      settle();
      er = (c == 3'h0 || c > 3'h5 || (c == 3'h5 && !i[3])) ? 8'h00 : {5'h00, c};
      cmp(8'(rx_term_ff), er);
      cmp(8'(tx_term_ff), (c == 3'h0 || c > 3'h5) ? 8'h06 : {5'h00, c});
    end
    $display("test termination done");
  endtask
  task automatic t_monitor();
    logic [1:0] k;
    for (int i = 0; i < 6; i++) begin
      k = 2'(i + 1);
      line_mode <= line_mode_e'({i >= 4, i[0]});
      wr(OFS_CTRL_C, {3'h0, k, 3'h0});
      settle();
      cmp({6'h00, monitor_boost_ff}, (i < 4) ? {6'h00, k} : 8'h00);
    end
    line_mode <= MODE_T1;
    $display("test monitor done");
  endtask
  task automatic t_cmi();
    logic p, v, p0;
    send_level <= 1'h1;
    wr(OFS_CTRL_C, 8'h80);
    settle();
    cmp({6'h00, cmi_enable_ff, rx_cmi_level_ff}, 8'h03);
    wr(OFS_CTRL_C, 8'hc0);
    settle();
    cmp({6'h00, cmi_enable_ff, rx_cmi_level_ff}, 8'h02);
    wr(OFS_CTRL_C, 8'h40);
    settle();
    cmp({6'h00, cmi_enable_ff, rx_cmi_level_ff}, 8'h01);
    wr(OFS_CTRL_B, 8'h10);
    wr(OFS_CTRL_C, 8'h80);
    send(1'h0, p, v);
    cmp_bit(p, 1'h0);
    mid(p);
    cmp_bit(p, 1'h1);
    send(1'h1, p0, v);
    send(1'h1, p, v);
    cmp_bit(p, ~p0);
    wr(OFS_CTRL_C, 8'hc0);
    send(1'h0, p, v);
    cmp_bit(p, 1'h1);
    mid(p);
    cmp_bit(p, 1'h0);
    $display("test mark inversion done");
  endtask
  task automatic t_stream();
    logic p, v, p0;
    wr(OFS_CTRL_C, 8'h00);
    wr(OFS_CTRL_B, 8'h10);
    send(1'h0, p, v);
    cmp_bit(p, 1'h0);
    wr(OFS_CTRL_B, 8'h30);
    for (int k = 0; k < 4; k++) begin
      send(1'h1, p, v);
      cmp({6'h00, p, v}, {6'h00, 1'h1, k == 2});
    end
    wr(OFS_CTRL_B, 8'h30);
    send(1'h1, p, v);
    cmp_bit(v, 1'h0);
    wr(OFS_CTRL_B, 8'h10);
    wr(OFS_CTRL_B, 8'h30);
    send(1'h1, p, v);
    cmp_bit(v, 1'h1);
    wr(OFS_CTRL_B, 8'h00);
    send(1'h0, p, v);
    cmp_bit(p, 1'h1);
    wr(OFS_CTRL_B, 8'h10);
    wr(OFS_CTRL_C, 8'h01);
    send(1'h1, p0, v);
    send(1'h1, p, v);
    cmp_bit(p, ~p0);
    send(1'h1, p, v);
    cmp_bit(p, p0);
    $display("test transmit stream done");
  endtask
  task automatic t_hw();
    logic [7:0] n;
    hw_mode <= 1'h1;
    pins <= 4'hb;
    wr(OFS_CTRL_B, 8'he7);
    wr(OFS_CTRL_D, 8'h7f);
    settle();
    cmp(8'(attenuator_clock_ff), 8'h0a);
    rd_chk(OFS_CTRL_B, 8'h18);
    rd_chk(OFS_CTRL_D, 8'h80);
    wr(OFS_CTRL_B, 8'h00);
    wr(OFS_CTRL_B, 8'h40);
    reset_pulses(n);
    cmp(n, 8'h00);
    hw_mode <= 1'h0;
    $display("test hardware mode done");
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    t_regs();
    t_gain_driver();
    t_limit_filter();
    t_atten();
    t_trigger();
    t_term();
    t_monitor();
    t_cmi();
    t_stream();
    t_hw();
    print_verdict();
  end
  initial begin
    #3000000;
    n_fail++;
    print_verdict();
  end
endmodule
